// File: rtl/uart_frame_core.sv
// serial port register map with character framing (tx and rx)
// assumes an avalon-mm master on clk_i; serial_in already synchronous
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1: data bit zero sent and received first
// RULE2: non-fifo mode zeroes timeout, fifo, error bits
// RULE3: even select gives even ones count
// RULE4: even cleared gives odd ones count
// RULE5: even select ignored without parity enable
// RULE6: transmitter inserts parity after last data
// RULE7: receiver checks parity after last data
// RULE8: stop select cleared gives one stop
// RULE9: stop select with five bits: 1.5
// RULE10: stop select with six-eight bits: two
// RULE11: length bits select five to eight
// RULE12: divisor access remaps offsets zero and one
// RULE13: stick parity forces bit from even select
// RULE14: silence forces infrared output low only
// RULE15: baud tick runs at sixteen times rate
// RULE16: offset two reads status, writes fifo control
// RULE17: offset zero reads rx, writes tx byte
module uart_frame_core
    import uart_frame_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // avalon-mm slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // serial line
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic infrared_tx_out_o,
    // interrupt
    output logic irq_o
);
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

    logic [7:0] line_control;
    logic [7:0] int_enable;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] scratch;
    logic [15:0] divisor;
    logic [7:0] tx_buffer;
    logic [7:0] rx_buffer;
    logic [EV_W-1:0] evt_status;
    logic [EV_W-1:0] evt_mask;
    logic tx_full;
    logic rx_ready;
    logic rx_par_err;
    logic rx_stop_err;
    logic rx_overrun;
    logic ack;
    logic [15:0] baud_cnt;
    logic tick;
    tx_state_t tx_state;
    rx_state_t rx_state;
    logic [3:0] tx_sub;
    logic [2:0] tx_idx;
    logic [1:0] tx_stops;
    logic [7:0] tx_shift;
    logic tx_line;
    logic tx_done;
    logic [3:0] rx_sub;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift;
    logic rx_done;
    logic rx_perr_ev;
    logic rx_serr_ev;

    // access decode
    logic [3:0] idx;
    logic wr_lo;
    logic rd_acc;
    logic wr_acc;
    logic dl;
    logic [2:0] last_bit;
    logic [3:0] len_n;
    assign idx = avs_address_i[5:2];
    assign dl = line_control[LC_DIV_ACCESS];
    // single-cycle wait lets the read mux register its data
    assign rd_acc = avs_read_i && ack;
    assign wr_acc = avs_write_i && ack;
    assign wr_lo = wr_acc && avs_byteenable_i[0];
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    // RULE11: length select
    // last data index is 4 plus the length code
    assign last_bit = {1'b1, line_control[LC_LEN_HI], line_control[LC_LEN_LO]};
    assign len_n = {2'b00, line_control[LC_LEN_HI], line_control[LC_LEN_LO]};

    always_ff @(posedge clk_i)
    begin
        if (srst_i || ack)
            ack <= 1'b0;
        else if (avs_read_i || avs_write_i)
            ack <= 1'b1;
    end

    // RULE12: divisor access remap on writes
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            line_control <= LC_RESET;
            int_enable <= BYTE_ZERO;
            fifo_control <= BYTE_ZERO;
            modem_control <= BYTE_ZERO;
            scratch <= BYTE_ZERO;
            divisor <= DIV_RESET;
            evt_mask <= '0;
        end
        else if (wr_lo)
        begin
            case (idx)
                {1'b0, IDX_DATA}:
                    if (dl)
                        divisor[7:0] <= avs_writedata_i[7:0];
                {1'b0, IDX_IER}:
                    if (dl)
                        divisor[15:8] <= avs_writedata_i[7:0];
                    else
                        int_enable <= {4'h0, avs_writedata_i[3:0]};
                // RULE16: write side of offset two
                {1'b0, IDX_ISTAT}: fifo_control <= {avs_writedata_i[7:6], 2'b00, avs_writedata_i[3], 2'b00,
                    avs_writedata_i[0]};
                {1'b0, IDX_LCR}: line_control <= avs_writedata_i[7:0];
                {1'b0, IDX_MCR}: modem_control <= {3'h0, avs_writedata_i[4:0]};
                {1'b0, IDX_SCR}: scratch <= avs_writedata_i[7:0];
                IDX_EVT_MASK: evt_mask <= avs_writedata_i[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // RULE17: tx buffer load, freed when the shifter takes it
    logic tx_load;
    assign tx_load = wr_lo && idx == {1'b0, IDX_DATA} && !dl;
    logic tx_take;
    assign tx_take = tx_state == TX_IDLE && tx_full && tick;
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_full <= 1'b0;
            tx_buffer <= BYTE_ZERO;
        end
        else if (tx_load)
        begin
            tx_full <= 1'b1;
            tx_buffer <= avs_writedata_i[7:0];
        end
        else if (tx_take)
            tx_full <= 1'b0;
    end

    // RULE15: divider gives the 16x tick
    always_ff @(posedge clk_i)
    begin
        if (srst_i || baud_cnt >= divisor - 16'h0001)
            baud_cnt <= 16'h0000;
        else
            baud_cnt <= baud_cnt + 16'h0001;
    end
    assign tick = baud_cnt >= divisor - 16'h0001;

    // parity over active data bits
    function automatic logic calc_par(input logic [7:0] d, input logic [1:0] len, input logic [7:0] lc);
        logic [7:0] m;
        logic p;
        m = 8'hFF >> (2'h3 - len);
        p = ^(d & m);
        // RULE13: stick parity forced
        // RULE3: even select gives even total
        // RULE4: odd otherwise
        if (lc[LC_STICK])
            calc_par = !lc[LC_EVEN];
        else
            calc_par = lc[LC_EVEN] ? p : !p;
    endfunction

    // stop count in half bits: 2, 3 or 4
    logic [1:0] stop_halves_m1;
    // RULE8: one stop
    // RULE9: one and a half
    // RULE10: two stops
    assign stop_halves_m1 = !line_control[LC_STOP] ? 2'd1 : (len_n[1:0] == 2'b00 ? 2'd2 : 2'd3);

    // transmitter
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_state <= TX_IDLE;
            tx_sub <= 4'h0;
            tx_idx <= 3'h0;
            tx_stops <= 2'd0;
            tx_shift <= BYTE_ZERO;
            tx_line <= 1'b1;
            tx_done <= 1'b0;
        end
        else
        begin
            tx_done <= 1'b0;
            if (tick)
            begin
                tx_sub <= tx_sub + 4'h1;
                case (tx_state)
                    TX_IDLE:
                        if (tx_full)
                        begin
                            tx_shift <= tx_buffer;
                            tx_state <= TX_START;
                            tx_line <= 1'b0;
                            tx_sub <= 4'h0;
                        end
                    TX_START:
                        if (tx_sub == LAST_TICK)
                        begin
                            // RULE1: bit zero first
                            tx_line <= tx_shift[0];
                            tx_idx <= 3'h0;
                            tx_state <= TX_DATA;
                        end
                    TX_DATA:
                        if (tx_sub == LAST_TICK)
                        begin
                            if (tx_idx == last_bit)
                            begin
                                // RULE6: parity after last data
                                // RULE5: parity only when enabled
                                if (line_control[LC_PAR_EN])
                                begin
                                    tx_line <= calc_par(tx_shift, len_n[1:0], line_control);
                                    tx_state <= TX_PAR;
                                end
                                else
                                begin
                                    tx_line <= 1'b1;
                                    tx_stops <= stop_halves_m1;
                                    tx_state <= TX_STOP;
                                end
                            end
                            else
                            begin
                                tx_idx <= tx_idx + 3'h1;
                                tx_line <= tx_shift[tx_idx + 3'h1];
                            end
                        end
                    TX_PAR:
                        if (tx_sub == LAST_TICK)
                        begin
                            tx_line <= 1'b1;
                            tx_stops <= stop_halves_m1;
                            tx_state <= TX_STOP;
                        end
                    TX_STOP:
                        if (tx_sub == HALF_BIT || tx_sub == LAST_TICK)
                        begin
                            if (tx_stops == 2'd0)
                            begin
                                tx_state <= TX_IDLE;
                                tx_done <= 1'b1;
                            end
                            else
                                tx_stops <= tx_stops - 2'd1;
                        end
                    default: tx_state <= TX_IDLE;
                endcase
            end
        end
    end
    assign serial_out_o = tx_line;
    // RULE14: silence affects only the infrared output
    assign infrared_tx_out_o = line_control[LC_SILENCE] ? 1'b0 : tx_line;

    // receiver
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rx_state <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= BYTE_ZERO;
            rx_done <= 1'b0;
            rx_perr_ev <= 1'b0;
            rx_serr_ev <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            rx_perr_ev <= 1'b0;
            rx_serr_ev <= 1'b0;
            if (tick)
            begin
                rx_sub <= rx_sub + 4'h1;
                case (rx_state)
                    RX_IDLE:
                        if (!serial_in_i)
                        begin
                            rx_sub <= 4'h0;
                            rx_state <= RX_START;
                        end
                    RX_START:
                        if (rx_sub == HALF_BIT)
                        begin
                            // false start glitch returns to idle
                            if (serial_in_i)
                                rx_state <= RX_IDLE;
                            else
                            begin
                                rx_sub <= 4'h0;
                                rx_idx <= 3'h0;
                                rx_shift <= BYTE_ZERO;
                                rx_state <= RX_DATA;
                            end
                        end
                    RX_DATA:
                        if (rx_sub == LAST_TICK)
                        begin
                            // RULE1: ascending bit order
                            rx_shift[rx_idx] <= serial_in_i;
                            rx_idx <= rx_idx + 3'h1;
                            if (rx_idx == last_bit)
                                rx_state <= line_control[LC_PAR_EN] ? RX_PAR : RX_STOP;
                        end
                    RX_PAR:
                        if (rx_sub == LAST_TICK)
                        begin
                            // RULE7: check parity after last data
                            rx_perr_ev <= serial_in_i != calc_par(rx_shift, len_n[1:0], line_control);
                            rx_state <= RX_STOP;
                        end
                    RX_STOP:
                        // only the first stop is checked; extra stop time is idle
                        if (rx_sub == LAST_TICK)
                        begin
                            rx_serr_ev <= !serial_in_i;
                            rx_done <= 1'b1;
                            rx_state <= RX_IDLE;
                        end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // status bits: set wins over read-clear
    logic rd_data;
    logic rd_lsr;
    assign rd_data = rd_acc && idx == {1'b0, IDX_DATA} && !dl;
    assign rd_lsr = rd_acc && idx == {1'b0, IDX_LSR};
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rx_buffer <= BYTE_ZERO;
            rx_ready <= 1'b0;
            rx_par_err <= 1'b0;
            rx_stop_err <= 1'b0;
            rx_overrun <= 1'b0;
        end
        else
        begin
            if (rx_done)
            begin
                rx_buffer <= rx_shift;
                rx_ready <= 1'b1;
            end
            else if (rd_data)
                rx_ready <= 1'b0;
            rx_par_err <= rx_perr_ev || (rx_par_err && !rd_lsr);
            rx_stop_err <= rx_serr_ev || (rx_stop_err && !rd_lsr);
            rx_overrun <= (rx_done && rx_ready && !rd_data) || (rx_overrun && !rd_lsr);
        end
    end

    // sticky events, write one to clear, set wins
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    assign ev_set = {rx_done && rx_ready && !rd_data, rx_serr_ev, rx_perr_ev, tx_done, rx_done};
    assign ev_clr = (wr_lo && idx == IDX_EVT) ? avs_writedata_i[EV_W-1:0] : '0;
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            evt_status <= '0;
        else
            evt_status <= ev_set | (evt_status & ~ev_clr);
    end
    assign irq_o = |(evt_status & evt_mask);

    // interrupt identification, legacy priority order
    logic [7:0] int_status;
    logic fifo_mode;
    assign fifo_mode = fifo_control[FC_FIFO_EN];
    always_comb
    begin
        int_status = 8'h01;
        if (int_enable[2] && (rx_par_err || rx_stop_err || rx_overrun))
            int_status[3:0] = 4'h6;
        else if (int_enable[0] && rx_ready)
            int_status[3:0] = 4'h4;
        else if (int_enable[1] && !tx_full)
            int_status[3:0] = 4'h2;
        // RULE2: fifo flags only in fifo mode; no timeout source here
        int_status[7:6] = fifo_mode ? 2'b11 : 2'b00;
    end

    // read mux registered during the wait cycle
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (avs_read_i && !ack)
        begin
            avs_readdata_o <= 32'h0000_0000;
            case (idx)
                // RULE12: divisor access remap on reads
                {1'b0, IDX_DATA}: avs_readdata_o[7:0] <= dl ? divisor[7:0] : rx_buffer;
                {1'b0, IDX_IER}: avs_readdata_o[7:0] <= dl ? divisor[15:8] : int_enable;
                // RULE16: read side of offset two
                {1'b0, IDX_ISTAT}: avs_readdata_o[7:0] <= int_status;
                {1'b0, IDX_LCR}: avs_readdata_o[7:0] <= line_control;
                {1'b0, IDX_MCR}: avs_readdata_o[7:0] <= modem_control;
                // RULE2: error summary bit zero outside fifo mode
                {1'b0, IDX_LSR}: avs_readdata_o[7:0] <= {fifo_mode && (rx_par_err || rx_stop_err),
                    !tx_full && tx_state == TX_IDLE, !tx_full, 1'b0, rx_stop_err, rx_par_err,
                    rx_overrun, rx_ready};
                {1'b0, IDX_MSR}: avs_readdata_o[7:0] <= BYTE_ZERO;
                {1'b0, IDX_SCR}: avs_readdata_o[7:0] <= scratch;
                IDX_EVT: avs_readdata_o[EV_W-1:0] <= evt_status;
                IDX_EVT_MASK: avs_readdata_o[EV_W-1:0] <= evt_mask;
                default: ;
            endcase
        end
    end

    // assertions
    // RULE14: silence check
    AST_SILENCE: assert property (@(posedge clk_i) disable iff (srst_i) // RULE14
        line_control[LC_SILENCE] |-> !infrared_tx_out_o && serial_out_o == tx_line)
        else $error("infrared output not silenced");
    // RULE2: legacy mode zeros
    AST_LEGACY_ZERO: assert property (@(posedge clk_i) disable iff (srst_i) // RULE2
        !fifo_mode |-> int_status[7:6] == 2'b00 && !int_status[3])
        else $error("fifo bits set in legacy mode");
    // RULE6: parity follows last data
    AST_PAR_AFTER: assert property (@(posedge clk_i) disable iff (srst_i) // RULE6
        tx_state == TX_PAR && $past(tx_state) != TX_PAR |-> $past(tx_state) == TX_DATA && $past(tx_idx) == last_bit)
        else $error("parity before data");
    // RULE1: bit zero leads
    AST_BIT0_FIRST: assert property (@(posedge clk_i) disable iff (srst_i) // RULE1
        tx_state == TX_DATA && $past(tx_state) == TX_START |-> serial_out_o == tx_shift[0])
        else $error("first data bit is not bit zero");
    // RULE8: stop time is high
    AST_STOP_HIGH: assert property (@(posedge clk_i) disable iff (srst_i) // RULE8
        tx_state == TX_STOP |-> serial_out_o)
        else $error("line low during stop time");
    // RULE15: tick period equals divisor
    AST_TICK: assert property (@(posedge clk_i) disable iff (srst_i) // RULE15
        tick && divisor == 16'h0002 && $stable(divisor) && !wr_acc |=> !tick ##1 tick)
        else $error("baud tick period wrong");
endmodule : uart_frame_core

`default_nettype wire

// File: rtl/uart_frame_pkg.sv
// constants for the serial port register map and framing logic
// used by uart_frame_core; no other dependencies
package uart_frame_pkg;
    // register word indices (byte address = 4 * index)
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IER = 3'h1;
    localparam logic [2:0] IDX_ISTAT = 3'h2;
    localparam logic [2:0] IDX_LCR = 3'h3;
    localparam logic [2:0] IDX_MCR = 3'h4;
    localparam logic [2:0] IDX_LSR = 3'h5;
    localparam logic [2:0] IDX_MSR = 3'h6;
    localparam logic [2:0] IDX_SCR = 3'h7;
    // extra registers: sticky event status and its mask
    localparam logic [3:0] IDX_EVT = 4'h8;
    localparam logic [3:0] IDX_EVT_MASK = 4'h9;
    // line control fields
    localparam int LC_LEN_LO = 0;
    localparam int LC_LEN_HI = 1;
    localparam int LC_STOP = 2;
    localparam int LC_PAR_EN = 3;
    localparam int LC_EVEN = 4;
    localparam int LC_STICK = 5;
    localparam int LC_SILENCE = 6;
    localparam int LC_DIV_ACCESS = 7;
    // fifo control field
    localparam int FC_FIFO_EN = 0;
    // event bits
    localparam int EV_RX_DONE = 0;
    localparam int EV_TX_DONE = 1;
    localparam int EV_PAR_ERR = 2;
    localparam int EV_STOP_ERR = 3;
    localparam int EV_OVERRUN = 4;
    localparam int EV_W = 5;
    // reset values
    localparam logic [7:0] LC_RESET = 8'h03;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // 16x oversampling
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] HALF_BIT = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hF;
endpackage : uart_frame_pkg

// File: tb/serial_peer.sv
// serial peer model: sends and samples async frames, 16 clocks a bit
// assumes divisor 1, so one baud tick per clk_i cycle
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
    // clock
    input wire logic clk_i,
    // line from and to the block
    input wire logic line_i,
    output logic line_o
);
    int cyc = 0;
    always @(negedge clk_i) cyc <= cyc + 1;
    initial line_o = 1'b1;

    task automatic send(input logic [11:0] f, input int nb);
        @(posedge clk_i) line_o <= 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            repeat (16) @(posedge clk_i);
            line_o <= f[i];
        end
        repeat (16) @(posedge clk_i);
        // line driven back to its idle high level
        line_o <= 1'b1;
    endtask : send

    // lowest bit taken first; samples mid-bit
    task automatic grab(input int nb, output logic [11:0] f, output int t0, output bit to);
        int k;
        f = 12'hFFF;
        k = 0;
        while (line_i !== 1'b0 && k < 4000)
        begin
            @(negedge clk_i);
            k++;
        end
        to = (k >= 4000);
        t0 = cyc;
        repeat (8) @(negedge clk_i);
        for (int i = 0; i < nb; i++)
        begin
            repeat (16) @(negedge clk_i);
            f[i] = line_i;
        end
    endtask : grab
endmodule : serial_peer
`default_nettype wire

// File: tb/uart_frame_core_tb.sv
// register and framing bench for uart_frame_core
// assumes serial_peer on the line side and divisor left at 1
`timescale 1ns/10ps
`default_nettype none
module uart_frame_core_tb;
    import uart_frame_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [5:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [3:0] avs_byteenable_i = 4'h1;
    logic [31:0] avs_writedata_i = '0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, serial_in_i, serial_out_o, infrared_tx_out_o, irq_o;
    int n_errors = 0;
    int n_tests = 0;
    logic [7:0] lcr = 8'h03;
    logic [7:0] c, d;
    logic [11:0] f, ga, gb;
    int n, nb, t0, t1, ex;
    bit to, to2;
    logic [7:0] cfg [11] = '{8'h03, 8'h00, 8'h1B, 8'h0A, 8'h07, 8'h04, 8'h2B, 8'h23, 8'h13, 8'h05, 8'h43};
    logic [7:0] dat [11] = '{8'h4B, 8'hF3, 8'h96, 8'h35, 8'hC1, 8'h0E, 8'h69, 8'h5A, 8'hA7, 8'h2D, 8'h81};

    always #25 clk_i = ~clk_i;

    uart_frame_core dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
        .infrared_tx_out_o(infrared_tx_out_o), .irq_o(irq_o));
    serial_peer peer (.clk_i(clk_i), .line_i(serial_out_o), .line_o(serial_in_i));

    task automatic end_of_test();
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : chk

    // request held until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] rq);
        int k;
        logic ws;
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {24'h0, wd};
        avs_write_i <= w;
        avs_read_i <= ~w;
        k = 0;
        ws = 1'b1;
        while (ws !== 1'b0 && k < 20)
        begin
            @(posedge clk_i);
            ws = avs_waitrequest_o;
            rq = avs_readdata_o[7:0];
            k++;
        end
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (ws !== 1'b0)
        begin
            n_errors++;
            end_of_test();
        end
        if (w && idx == 4'(IDX_LCR))
            lcr = wd;
        @(posedge clk_i);
    endtask : acc

    task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
        logic [7:0] rq;
        acc(1'b1, idx, wd, rq);
    endtask : wr

    task automatic rc(input string s, input logic [3:0] idx, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] rq;
        acc(1'b0, idx, 8'h00, rq);
        chk(s, e & m, rq & m);
    endtask : rc

    // bounded poll for the receive-done event
    task automatic wait_rx();
        logic [7:0] rq;
        int k;
        k = 0;
        rq = 8'h00;
        while (rq[EV_RX_DONE] !== 1'b1 && k < 300)
        begin
            acc(1'b0, IDX_EVT, 8'h00, rq);
            k++;
        end
        chk("rx done", 1, rq[EV_RX_DONE]);
    endtask : wait_rx

    function automatic logic [11:0] mk(input logic [7:0] cc, input logic [7:0] dd);
        logic [11:0] r;
        logic [7:0] dm;
        int len;
        len = 5 + cc[1:0];
        dm = dd & (8'hFF >> (3 - cc[1:0]));
        r = {4'hF, dm | ~(8'hFF >> (3 - cc[1:0]))};
        if (cc[LC_PAR_EN])
            r[len] = cc[LC_STICK] ? ~cc[LC_EVEN] : ~(cc[LC_EVEN] ^ (^dm));
        return r;
    endfunction : mk

    always @(negedge clk_i)
        if (!srst_i && infrared_tx_out_o !== (lcr[LC_SILENCE] ? 1'b0 : serial_out_o))
            chk("infrared out", serial_out_o & ~lcr[LC_SILENCE], infrared_tx_out_o);

    initial
    begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rc("line_control", IDX_LCR, LC_RESET, 8'hFF);
        rc("int_status", IDX_ISTAT, 8'h01, 8'hFF);
        rc("line_status", IDX_LSR, 8'h00, 8'h80);
        wr(IDX_SCR, 8'hA5);
        rc("scratch", IDX_SCR, 8'hA5, 8'hFF);
        rc("unmapped", 4'hF, 8'h00, 8'hFF);
        wr(IDX_LCR, 8'h83);
        wr(IDX_DATA, 8'h34);
        wr(IDX_IER, 8'h12);
        rc("divisor_low", IDX_DATA, 8'h34, 8'hFF);
        rc("divisor_high", IDX_IER, 8'h12, 8'hFF);
        wr(IDX_DATA, 8'h02);
        wr(IDX_IER, 8'h00);
        rc("divisor_low", IDX_DATA, 8'h02, 8'hFF);
        // divisor two exercises the tick period check
        repeat (8) @(posedge clk_i);
        wr(IDX_DATA, 8'h01);
        wr(IDX_IER, 8'h00);
        wr(IDX_LCR, 8'h03);
        wr(IDX_IER, 8'h0F);
        rc("int_enable", IDX_IER, 8'h0F, 8'hFF);
        wr(IDX_IER, 8'h00);
        wr(IDX_ISTAT, 8'h01);
        rc("int_status", IDX_ISTAT, 8'hC1, 8'hFF);
        wr(IDX_ISTAT, 8'h00);
        rc("int_status", IDX_ISTAT, 8'h01, 8'hFF);
        for (int j = 0; j < 11; j++)
        begin
            c = cfg[j];
            d = dat[j];
            n = 5 + c[1:0];
            nb = n + c[LC_PAR_EN] + 1;
            f = mk(c, d);
            wr(IDX_LCR, c);
            fork
                peer.grab(nb, ga, t0, to);
                begin
                    wr(IDX_DATA, d);
                    repeat (20) @(posedge clk_i);
                    wr(IDX_DATA, ~d);
                end
            join
            peer.grab(nb, gb, t1, to2);
            chk("tx frame", f, ga);
            chk("tx frame b", mk(c, ~d), gb);
            chk("tx timeout", 0, to | to2);
            ex = (1 + nb - 1) * 16 + (c[LC_STOP] ? (n == 5 ? 24 : 32) : 16);
            chk("tx gap", ex, (t1 - t0 >= ex && t1 - t0 <= ex + 2) ? ex : t1 - t0);
            wr(IDX_EVT, 8'h1F);
            peer.send(f, nb + 1);
            wait_rx();
            rc("rx_buffer", IDX_DATA, d, 8'hFF >> (3 - c[1:0]));
            rc("rx errors", IDX_EVT, 8'h00, 8'h0C);
        end
        wr(IDX_LCR, 8'h1B);
        wr(IDX_EVT_MASK, 8'h04);
        wr(IDX_EVT, 8'h1F);
        f = mk(8'h1B, 8'h96);
        peer.send(f ^ 12'h100, 10);
        wait_rx();
        chk("irq", 1, irq_o);
        rc("parity error", IDX_EVT, 8'h04, 8'h0C);
        wr(IDX_EVT_MASK, 8'h00);
        chk("irq masked", 0, irq_o);
        wr(IDX_EVT_MASK, 8'h04);
        chk("irq unmasked", 1, irq_o);
        wr(IDX_EVT, 8'h04);
        chk("irq cleared", 0, irq_o);
        wr(IDX_EVT, 8'h1F);
        peer.send(f & ~12'h200, 10);
        wait_rx();
        rc("stop error", IDX_EVT, 8'h08, 8'h0C);
        end_of_test();
    end
endmodule : uart_frame_core_tb
`default_nettype wire
